// ==== src/srap_defines.svh ====
// Purpose: constants shared by both ends of the serial register access port
// Assumes: SPI mode 3 style framing, MSB first
// Notes: register codes, field positions, reset values and timing counts
//
// Summary of operation
// - sample input on rising, drive output falling
// - all words shift most significant bit first
// - chip select high: output released, link ignored
// - three-wire host holds chip select low
// - seven registers of 8, 16, 24 bits
// - idle after reset and each transfer: command next
// - command byte then full-length register access
// - thirty-two ones resynchronise, registers untouched
// - command waits until a zero start bit
// - command read MSB is live ready flag
// - three select bits choose next register
// - direction bit: zero write, one read
// - power-down bit; clock output keeps running
// - channel bits pick channel and coefficient pair
// - command register readable with live ready bit
// - setup register read-write, mode bits reset zero
// - filter settles three periods after restart
// - hold release: valid three periods later
// - word rate equals first notch frequency
// - rate bits move notches, shape unchanged
// - internal oscillator bit picks 1 or 2.4576 MHz
// - select codes map registers as listed
// - hold stops conversion; ready low stays low
`ifndef SRAP_DEFINES_SVH
`define SRAP_DEFINES_SVH

// register select codes
`define SRAP_RS_COMM 3'h0
`define SRAP_RS_SETUP 3'h1
`define SRAP_RS_CLOCK 3'h2
`define SRAP_RS_DATA 3'h3
`define SRAP_RS_TEST 3'h4
`define SRAP_RS_NOP 3'h5
`define SRAP_RS_OFFSET 3'h6
`define SRAP_RS_GAIN 3'h7

// command byte fields
`define SRAP_CMD_START 7
`define SRAP_CMD_RS_HI 6
`define SRAP_CMD_RS_LO 4
`define SRAP_CMD_DIR 3
`define SRAP_CMD_PD 2
`define SRAP_CMD_CH_HI 1
`define SRAP_CMD_CH_LO 0

// setup byte fields
`define SRAP_SET_MD_HI 7
`define SRAP_SET_MD_LO 6
`define SRAP_SET_HOLD 0

// clock byte fields
`define SRAP_CLK_DIS 4
`define SRAP_CLK_HALVE 3
`define SRAP_CLK_FREQ 2
`define SRAP_CLK_FS_HI 1
`define SRAP_CLK_FS_LO 0

// reset values
`define SRAP_RST_COMM 8'h00
`define SRAP_RST_SETUP 8'h01
`define SRAP_RST_CLOCK 8'h85
`define SRAP_RST_OFFSET 24'h1F_4000
`define SRAP_RST_GAIN 24'h57_61AB

// resynchronisation run length
`define SRAP_RESYNC_ONES 6'd32
// filter settling in output periods
`define SRAP_SETTLE_SYNC 3'd3
`define SRAP_SETTLE_STEP 3'd4

// link timing: host holds the serial clock high one CLK cycle longer than this time and low one CLK cycle short of twice it
`define SRAP_SCLK_HALF_NS 160
`define SRAP_CLK_NS 40
`define SRAP_SCLK_HALF_CYC ((`SRAP_SCLK_HALF_NS + `SRAP_CLK_NS - 1) / `SRAP_CLK_NS)

`endif

// ==== src/srap_pkg.sv ====
// Purpose: types shared by both ends of the serial register access port
// Assumes: constants live in srap_defines.svh
// Notes: one-hot state codes
package srap_pkg;

    typedef enum logic [3:0] {
        SRAP_DEV_CMD = 4'b0001,
        SRAP_DEV_WR = 4'b0010,
        SRAP_DEV_RD = 4'b0100,
        SRAP_DEV_SKIP = 4'b1000
    } srap_dev_state_t;

    typedef enum logic [3:0] {
        SRAP_HST_IDLE = 4'b0001,
        SRAP_HST_LOW = 4'b0010,
        SRAP_HST_HIGH = 4'b0100,
        SRAP_HST_END = 4'b1000
    } srap_hst_state_t;

endpackage : srap_pkg

// ==== src/srap_link_if.sv ====
// Purpose: four-wire serial link between host and device
// Assumes: output enable is active low
// Notes: the host reads the data-out wire directly; sdo_oe_n only feeds the link checks
`timescale 1ns/100ps
interface srap_link_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;
    logic sdo_oe_n;
    logic result_ready_n;

    modport device (
        input sclk,
        input cs_n,
        input sdi,
        output sdo,
        output sdo_oe_n,
        output result_ready_n
    );

    modport host (
        output sclk,
        output cs_n,
        output sdi,
        input sdo,
        input sdo_oe_n,
        input result_ready_n
    );
endinterface : srap_link_if

// ==== src/srap_device.sv ====
// Purpose: device end: serial command protocol and register file
// Assumes: serial clock well below CLK/6, sampled by CLK
// Notes: the converter core is replaced by user-side sample inputs
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "srap_defines.svh"

module srap_device
    import srap_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // serial link
    srap_link_if.device LINK,
    // converter side
    input wire logic SAMPLE_STROBE,
    input wire logic [DATA_W-1:0] SAMPLE_DATA,
    // controls shown to the converter core
    output logic [1:0] CHANNEL,
    output logic POWER_DOWN,
    output logic FILTER_HOLD,
    output logic [1:0] CAL_MODE,
    output logic [7:0] CLOCK_CTRL,
    output logic OSC_OUT_EN,
    output logic RESULT_VALID
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [2:0] sdi_sync;
    logic sclk_lvl;
    logic cs_lvl;
    logic sdi_lvl;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sclk_sync <= 3'h7;
            cs_sync <= 3'h7;
            sdi_sync <= 3'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], LINK.sclk};
            cs_sync <= {cs_sync[1:0], LINK.cs_n};
            sdi_sync <= {sdi_sync[1:0], LINK.sdi};
        end
    end

    // a level is only taken once the second and third stages agree
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sclk_lvl <= 1'b1;
            cs_lvl <= 1'b1;
            sdi_lvl <= 1'b0;
        end else begin
            if (sclk_sync[1] == sclk_sync[2]) sclk_lvl <= sclk_sync[2];
            if (cs_sync[1] == cs_sync[2]) cs_lvl <= cs_sync[2];
            if (sdi_sync[1] == sdi_sync[2]) sdi_lvl <= sdi_sync[2];
        end
    end

    logic sclk_prev;
    logic rise;
    logic fall;
    logic selected;

    always_ff @(posedge CLK) begin
        if (!RESETN) sclk_prev <= 1'b1;
        else sclk_prev <= sclk_lvl;
    end

    // cs_n tied low gives three-wire operation with no extra mode
    assign selected = !cs_lvl;
    assign rise = selected && sclk_lvl && !sclk_prev;
    assign fall = selected && !sclk_lvl && sclk_prev;

    // ************************************************************
    // registers
    // ************************************************************
    srap_dev_state_t state;
    logic [7:0] comm;
    logic [7:0] setup;
    logic [7:0] clock_reg;
    logic [7:0] test_reg;
    logic [DATA_W-1:0] data_reg;
    logic [23:0] offset_reg [3];
    logic [23:0] gain_reg [3];
    logic ready_n;
    logic [23:0] shreg;
    logic [4:0] bitcnt;
    logic [5:0] ones_cnt;
    logic [23:0] rx_word;
    logic [1:0] pair;
    logic [7:0] next_cmd;
    logic data_read;

    // channel code 1-0 is the noise input and uses pair 0
    function automatic logic [1:0] chan_pair(input logic [1:0] ch);
        case (ch)
            2'h1: chan_pair = 2'h1;
            2'h3: chan_pair = 2'h2;
            default: chan_pair = 2'h0;
        endcase
    endfunction : chan_pair

    assign pair = chan_pair(comm[`SRAP_CMD_CH_HI:`SRAP_CMD_CH_LO]);

    // width of the register picked by the command
    function automatic logic [4:0] reg_len(input logic [2:0] rs);
        case (rs)
            `SRAP_RS_DATA: reg_len = 5'(DATA_W);
            `SRAP_RS_OFFSET, `SRAP_RS_GAIN: reg_len = 5'd24;
            default: reg_len = 5'd8;
        endcase
    endfunction : reg_len

    // read image, left aligned so bit 23 goes out first
    // built from the incoming command: comm only takes it at this same edge
    function automatic logic [23:0] rd_image(input logic [7:0] cmd);
        case (cmd[6:4])
            `SRAP_RS_COMM: rd_image = {ready_n, cmd[6:0], 16'h0000};
            `SRAP_RS_SETUP: rd_image = {setup, 16'h0000};
            `SRAP_RS_CLOCK: rd_image = {clock_reg, 16'h0000};
            `SRAP_RS_DATA: rd_image = {data_reg, (24 - DATA_W)'(0)};
            `SRAP_RS_TEST: rd_image = {test_reg, 16'h0000};
            `SRAP_RS_OFFSET: rd_image = offset_reg[chan_pair(cmd[1:0])];
            `SRAP_RS_GAIN: rd_image = gain_reg[chan_pair(cmd[1:0])];
            default: rd_image = 24'h00_0000;
        endcase
    endfunction : rd_image

    assign rx_word = {shreg[22:0], sdi_lvl};
    assign next_cmd = rx_word[7:0];

    // ************************************************************
    // protocol sequencer
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state <= SRAP_DEV_CMD;
            bitcnt <= 5'd0;
            shreg <= 24'h00_0000;
            ones_cnt <= 6'd0;
            comm <= `SRAP_RST_COMM;
        end else if (rise) begin
            ones_cnt <= sdi_lvl ? ((ones_cnt == `SRAP_RESYNC_ONES - 6'd1) ? 6'd0
                : ones_cnt + 6'd1) : 6'd0;
            if (sdi_lvl && ones_cnt == `SRAP_RESYNC_ONES - 6'd1) begin
                state <= SRAP_DEV_CMD;
                bitcnt <= 5'd0;
            end else begin
                case (state)
                    SRAP_DEV_CMD: begin
                        // leading ones keep the port waiting
                        if (bitcnt != 5'd0 || !sdi_lvl) begin
                            shreg <= rx_word;
                            bitcnt <= bitcnt + 5'd1;
                        end
                        if (bitcnt == 5'd7) begin
                            bitcnt <= 5'd0;
                            comm <= {1'b0, next_cmd[6:0]};
                            if (next_cmd[`SRAP_CMD_RS_HI:`SRAP_CMD_RS_LO] == `SRAP_RS_NOP)
                                state <= SRAP_DEV_CMD;
                            else if (next_cmd[`SRAP_CMD_DIR]) begin
                                state <= SRAP_DEV_RD;
                                shreg <= rd_image(next_cmd);
                            end else state <= SRAP_DEV_WR;
                        end
                    end
                    SRAP_DEV_WR, SRAP_DEV_RD: begin
                        if (state == SRAP_DEV_WR) shreg <= rx_word;
                        bitcnt <= bitcnt + 5'd1;
                        if (bitcnt == reg_len(comm[6:4]) - 5'd1) begin
                            bitcnt <= 5'd0;
                            state <= SRAP_DEV_CMD;
                        end
                    end
                    default: state <= SRAP_DEV_CMD;
                endcase
            end
        end else if (fall && state == SRAP_DEV_RD && bitcnt != 5'd0) begin
            shreg <= {shreg[22:0], 1'b0};
        end
    end

    logic wr_done;
    assign wr_done = rise && state == SRAP_DEV_WR && bitcnt == reg_len(comm[6:4]) - 5'd1
        && !(sdi_lvl && ones_cnt == `SRAP_RESYNC_ONES - 6'd1);
    assign data_read = rise && state == SRAP_DEV_RD && comm[6:4] == `SRAP_RS_DATA
        && bitcnt == reg_len(`SRAP_RS_DATA) - 5'd1;

    // register writes land only when the last bit is in
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            setup <= `SRAP_RST_SETUP;
            clock_reg <= `SRAP_RST_CLOCK;
            test_reg <= 8'h00;
            for (int i = 0; i < 3; i++) begin
                offset_reg[i] <= `SRAP_RST_OFFSET;
                gain_reg[i] <= `SRAP_RST_GAIN;
            end
        end else if (wr_done) begin
            case (comm[6:4])
                `SRAP_RS_SETUP: setup <= rx_word[7:0];
                `SRAP_RS_CLOCK: clock_reg <= rx_word[7:0];
                `SRAP_RS_TEST: test_reg <= rx_word[7:0];
                `SRAP_RS_OFFSET: offset_reg[pair] <= rx_word;
                `SRAP_RS_GAIN: gain_reg[pair] <= rx_word;
                default: test_reg <= test_reg;
            endcase
        end
    end

    // ************************************************************
    // result and ready flag
    // ************************************************************
    // a new sample wins over a clearing read in the same cycle
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ready_n <= 1'b1;
            data_reg <= '0;
        end else if (SAMPLE_STROBE && !setup[`SRAP_SET_HOLD]) begin
            ready_n <= 1'b0;
            data_reg <= SAMPLE_DATA;
        end else if (data_read) begin
            ready_n <= 1'b1;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            LINK.sdo <= 1'b0;
            LINK.sdo_oe_n <= 1'b1;
            LINK.result_ready_n <= 1'b1;
            CHANNEL <= 2'h0;
            POWER_DOWN <= 1'b0;
            FILTER_HOLD <= 1'b1;
            CAL_MODE <= 2'h0;
            CLOCK_CTRL <= `SRAP_RST_CLOCK;
            OSC_OUT_EN <= 1'b1;
            RESULT_VALID <= 1'b0;
        end else begin
            LINK.sdo <= shreg[23];
            LINK.sdo_oe_n <= !(selected && state == SRAP_DEV_RD);
            LINK.result_ready_n <= ready_n;
            CHANNEL <= comm[1:0];
            POWER_DOWN <= comm[`SRAP_CMD_PD];
            FILTER_HOLD <= setup[`SRAP_SET_HOLD];
            CAL_MODE <= setup[`SRAP_SET_MD_HI:`SRAP_SET_MD_LO];
            CLOCK_CTRL <= clock_reg;
            OSC_OUT_EN <= !clock_reg[`SRAP_CLK_DIS];
            RESULT_VALID <= !ready_n;
        end
    end

endmodule : srap_device

// ==== src/srap_host.sv ====
// Purpose: host end: drives transfers on the serial link for software
// Assumes: software port with one-cycle strobes, read data one cycle later
// Notes: host makes the serial clock by dividing CLK
`timescale 1ns/100ps
`include "srap_defines.svh"

module srap_host
    import srap_pkg::*;
#(
    parameter int HALF_CYC = `SRAP_SCLK_HALF_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // software port
    input wire logic [1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // serial link
    srap_link_if.host LINK
);

    // ************************************************************
    // software registers: 0 tx word, 1 control/go, 2 rx word, 3 status
    // ************************************************************
    localparam logic [1:0] A_TX = 2'h0;
    localparam logic [1:0] A_CTRL = 2'h1;
    localparam logic [1:0] A_RX = 2'h2;
    localparam logic [1:0] A_STAT = 2'h3;

    srap_hst_state_t state;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [5:0] nbits;
    logic keep_cs;
    logic [5:0] cnt;
    logic [7:0] div;
    logic [2:0] sdo_sync;
    logic [2:0] rdy_sync;
    logic sdo_lvl;
    logic rdy_lvl;
    logic busy;

    assign busy = state != SRAP_HST_IDLE;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sdo_sync <= 3'h0;
            rdy_sync <= 3'h7;
            sdo_lvl <= 1'b0;
            rdy_lvl <= 1'b1;
        end else begin
            sdo_sync <= {sdo_sync[1:0], LINK.sdo};
            rdy_sync <= {rdy_sync[1:0], LINK.result_ready_n};
            if (sdo_sync[1] == sdo_sync[2]) sdo_lvl <= sdo_sync[2];
            if (rdy_sync[1] == rdy_sync[2]) rdy_lvl <= rdy_sync[2];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) RDATA <= 32'h0000_0000;
        else if (RD) begin
            case (ADDR)
                A_TX: RDATA <= tx;
                A_CTRL: RDATA <= {25'h000_0000, keep_cs, nbits};
                A_RX: RDATA <= rx;
                default: RDATA <= {30'h0000_0000, rdy_lvl, busy};
            endcase
        end
    end

    // ************************************************************
    // shifter: a frame of nbits (1..63), MSB first
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state <= SRAP_HST_IDLE;
            tx <= 32'h0000_0000;
            rx <= 32'h0000_0000;
            nbits <= 6'd8;
            keep_cs <= 1'b0;
            cnt <= 6'd0;
            div <= 8'd0;
            LINK.sclk <= 1'b1;
            LINK.cs_n <= 1'b1;
            LINK.sdi <= 1'b1;
        end else begin
            case (state)
                SRAP_HST_IDLE: begin
                    if (WR && ADDR == A_TX) tx <= WDATA;
                    if (WR && ADDR == A_CTRL) begin
                        nbits <= (WDATA[5:0] == 6'd0) ? 6'd1 : WDATA[5:0];
                        keep_cs <= WDATA[6];
                        if (WDATA[7]) begin
                            state <= SRAP_HST_LOW;
                            LINK.cs_n <= 1'b0;
                            cnt <= 6'd0;
                            div <= 8'd0;
                            rx <= 32'h0000_0000;
                        end
                    end
                end
                SRAP_HST_LOW: begin
                    // drive data while clock is low, before the rising edge
                    LINK.sdi <= tx[31];
                    LINK.sclk <= 1'b0;
                    div <= div + 8'd1;
                    if (div == 8'(2 * HALF_CYC - 1)) begin
                        div <= 8'd0;
                        state <= SRAP_HST_HIGH;
                        LINK.sclk <= 1'b1;
                    end
                end
                SRAP_HST_HIGH: begin
                    div <= div + 8'd1;
                    if (div == 8'(HALF_CYC - 1)) begin
                        // device output settles over the high phase
                        rx <= {rx[30:0], sdo_lvl};
                        tx <= {tx[30:0], 1'b1};
                        div <= 8'd0;
                        cnt <= cnt + 6'd1;
                        state <= (cnt == nbits - 6'd1) ? SRAP_HST_END : SRAP_HST_LOW;
                    end
                end
                SRAP_HST_END: begin
                    // holding sdi high leaves any trailing ones harmless
                    LINK.sdi <= 1'b1;
                    LINK.cs_n <= keep_cs;
                    state <= SRAP_HST_IDLE;
                end
                default: state <= SRAP_HST_IDLE;
            endcase
        end
    end

endmodule : srap_host

// ==== verification/srap_link_sva.sv ====
// Purpose: link checks between host and device ends
// Assumes: host divider at its default of four CLK cycles
// Notes: phase lengths are fixed to that divider
`timescale 1ns/100ps
module srap_link_sva (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    input wire logic result_ready_n
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // ************************************************
    // link timing and ownership
    // ************************************************
    property p_high_len; $rose(sclk) |-> sclk [*5]; endproperty
    a_high_len: assert property (p_high_len) else $error("clock high too short");
    property p_low_len; $fell(sclk) |-> !sclk [*7] ##1 sclk; endproperty
    a_low_len: assert property (p_low_len) else $error("clock low length wrong");
    property p_idle_high; cs_n |-> sclk; endproperty
    a_idle_high: assert property (p_idle_high) else $error("clock low while idle");
    property p_sdi_hold; $rose(sclk) |-> $stable(sdi) [*3]; endproperty
    a_sdi_hold: assert property (p_sdi_hold) else $error("input moved on rise");
    // output must hold for three cycles from the rise, so the host samples a settled bit
    property p_sdo_hold; ($rose(sclk) && !sdo_oe_n) |-> $stable(sdo) [*3]; endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("output moved on rise");
    property p_oe_off; cs_n [*8] |-> sdo_oe_n; endproperty
    a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
    property p_oe_start; $fell(sdo_oe_n) |-> !cs_n; endproperty
    a_oe_start: assert property (p_oe_start) else $error("drive began deselected");
    property p_ready_hold; cs_n [*8] |-> !$rose(result_ready_n); endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready cleared idle");
    c_read: cover property ($fell(sdo_oe_n));
    c_ready: cover property ($fell(result_ready_n));
    c_frame: cover property ($fell(cs_n));
endmodule : srap_link_sva

// ==== verification/serial_register_access_port_tb.sv ====
// Purpose: end-to-end bench of host and device ends
// Assumes: host software map offsets 0 to 3
// Notes: expected values come from the register map
`timescale 1ns/100ps
module serial_register_access_port_tb;
    logic clk;
    logic resetn;
    logic [1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic sample_strobe;
    logic [15:0] sample_data;
    logic [1:0] channel;
    logic power_down;
    logic filter_hold;
    logic [1:0] cal_mode;
    logic [7:0] clock_ctrl;
    logic osc_out_en;
    logic result_valid;
    int errors = 0;
    int total_checks = 0;
    srap_link_if u_srap_link_if ();
    srap_device #(.DATA_W(16)) u_srap_device (.CLK(clk), .RESETN(resetn),
        .LINK(u_srap_link_if), .SAMPLE_STROBE(sample_strobe), .SAMPLE_DATA(sample_data),
        .CHANNEL(channel), .POWER_DOWN(power_down), .FILTER_HOLD(filter_hold),
        .CAL_MODE(cal_mode), .CLOCK_CTRL(clock_ctrl), .OSC_OUT_EN(osc_out_en),
        .RESULT_VALID(result_valid));
    srap_host u_srap_host (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .LINK(u_srap_link_if));
    srap_link_sva u_srap_link_sva (.CLK(clk), .RESETN(resetn), .sclk(u_srap_link_if.sclk),
        .cs_n(u_srap_link_if.cs_n), .sdi(u_srap_link_if.sdi), .sdo(u_srap_link_if.sdo),
        .sdo_oe_n(u_srap_link_if.sdo_oe_n), .result_ready_n(u_srap_link_if.result_ready_n));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ************************************************
    // shared tasks
    // ************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic sw_wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : sw_wr
    task automatic sw_rd(input logic [1:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : sw_rd
    // busy is polled, so a stuck frame ends the loop and counts once
    task automatic frame(input logic [31:0] tx, input int n, input logic keep,
        output logic [31:0] rx);
        logic [31:0] st;
        int k;
        sw_wr(2'd0, tx << (32 - n));
        sw_wr(2'd1, {24'h0, 1'b1, keep, 6'(n)});
        for (k = 0; k < 3000; k++) begin
            sw_rd(2'd3, st);
            if (st[0] !== 1'b1) break;
        end
        check({31'h0, st[0]}, 32'h0);
        sw_rd(2'd2, rx);
        if (n < 32) rx = rx & ((32'h1 << n) - 32'h1);
    endtask : frame
    task automatic reg_wr(input logic [7:0] cmd, input int n, input logic [31:0] v,
        input logic keep);
        logic [31:0] r;
        frame({24'h0, cmd}, 8, keep, r);
        frame(v, n, keep, r);
    endtask : reg_wr
    task automatic reg_chk(input logic [7:0] cmd, input int n, input logic [31:0] exp);
        logic [31:0] r;
        frame({24'h0, cmd}, 8, 1'b0, r);
        frame(32'h0, n, 1'b0, r);
        check(r, exp);
    endtask : reg_chk
    task automatic pulse(input logic [15:0] d);
        @(posedge clk);
        sample_strobe <= 1'b1;
        sample_data <= d;
        @(posedge clk);
        sample_strobe <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset;
        logic [7:0] cmds [5] = '{8'h08, 8'h18, 8'h28, 8'h68, 8'h78};
        int lens [5] = '{8, 8, 8, 24, 24};
        logic [31:0] exps [5] = '{32'h88, 32'h01, 32'h85, 32'h1F_4000, 32'h57_61AB};
        check({24'h0, clock_ctrl}, 32'h85);
        check({30'h0, filter_hold, osc_out_en}, 32'h3);
        for (int i = 0; i < 5; i++) reg_chk(cmds[i], lens[i], exps[i]);
        $display("test reset done");
    endtask : t_reset
    task automatic t_setup;
        reg_wr(8'h10, 8, 32'hC2, 1'b1);
        check({29'h0, cal_mode, filter_hold}, 32'h6);
        reg_chk(8'h18, 8, 32'hC2);
        $display("test setup done");
    endtask : t_setup
    task automatic t_resync;
        logic [31:0] r;
        frame(32'h5, 4, 1'b1, r);
        check({30'h0, channel}, 32'h0);
        frame(32'hFFFF_FFFF, 32, 1'b0, r);
        frame(32'hF18, 12, 1'b0, r);
        frame(32'h0, 8, 1'b0, r);
        check(r, 32'hC2);
        $display("test resync done");
    endtask : t_resync
    task automatic t_chan;
        logic [31:0] r;
        for (int c = 0; c < 4; c++) begin
            frame(32'h50 | c, 8, 1'b0, r);
            check({29'h0, power_down, channel}, c);
        end
        frame(32'h54, 8, 1'b0, r);
        check({30'h0, power_down, osc_out_en}, 32'h3);
        frame(32'h50, 8, 1'b0, r);
        check({31'h0, power_down}, 32'h0);
        reg_wr(8'h20, 8, 32'h1C, 1'b0);
        check({23'h0, osc_out_en, clock_ctrl}, 32'h1C);
        reg_chk(8'h28, 8, 32'h1C);
        $display("test channel done");
    endtask : t_chan
    task automatic t_coef;
        reg_wr(8'h61, 24, 32'h12_3456, 1'b0);
        reg_chk(8'h68, 24, 32'h1F_4000);
        reg_chk(8'h69, 24, 32'h12_3456);
        reg_chk(8'h6A, 24, 32'h1F_4000);
        $display("test coefficient done");
    endtask : t_coef
    task automatic t_data;
        pulse(16'hA5C3);
        check({31'h0, u_srap_link_if.result_ready_n}, 32'h0);
        reg_wr(8'h10, 8, 32'h01, 1'b0);
        check({30'h0, u_srap_link_if.result_ready_n, result_valid}, 32'h1);
        reg_chk(8'h08, 8, 32'h08);
        reg_chk(8'h38, 16, 32'hA5C3);
        check({31'h0, u_srap_link_if.result_ready_n}, 32'h1);
        pulse(16'h1234);
        check({31'h0, u_srap_link_if.result_ready_n}, 32'h1);
        reg_chk(8'h38, 16, 32'hA5C3);
        $display("test data done");
    endtask : t_data
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        resetn = 1'b0;
        addr = 2'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        sample_strobe = 1'b0;
        sample_data = 16'h0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_setup();
        t_resync();
        t_chan();
        t_coef();
        t_data();
        print_verdict();
    end
    // a hung frame never clears busy, so cut the run short
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        print_verdict();
    end
endmodule : serial_register_access_port_tb
